// ### logic/spw_regs.svh
// Constants shared by both ends of the serial wiper control link.
`ifndef SPW_REGS_SVH
`define SPW_REGS_SVH
// Clock rate and timing.
`define SPW_CLK_MHZ 250
`define SPW_T_NV_WRITE_US 10000
`define SPW_SCK_HALF 8
// Reset values.
`define SPW_SYNC_RST 6'h19
`define SPW_WIPER_RST 10'h000
`define SPW_STORE_RST 10'h000
// Frame layout: bit counts and field positions.
`define SPW_BITS_SHORT 6'h10
`define SPW_BITS_LONG 6'h20
`define SPW_ID_TYPE_MSB 7
`define SPW_ID_TYPE_LSB 4
`define SPW_ID_ADDR_BIT 1
`define SPW_ID_RW_BIT 0
`define SPW_IN_OP_MSB 7
`define SPW_IN_OP_LSB 5
`define SPW_IN_PTR_MSB 3
`define SPW_IN_PTR_LSB 2
// Instruction keys {direction, opcode}; direction 1 reads.
`define SPW_CMD_RD_WIPER 4'hc
`define SPW_CMD_WR_WIPER 4'h5
`define SPW_CMD_RD_STORE 4'hd
`define SPW_CMD_WR_STORE 4'h6
`define SPW_CMD_XFR_TO_WIPER 4'he
`define SPW_CMD_XFR_TO_STORE 4'h7
`define SPW_CMD_RD_STATUS 4'ha
// Host register offsets and fields.
`define SPW_REG_CTRL 8'h00
`define SPW_REG_TXDATA 8'h04
`define SPW_REG_RXDATA 8'h08
`define SPW_REG_STATUS 8'h0c
`define SPW_REG_PINS 8'h10
`define SPW_CTRL_RW 0
`define SPW_CTRL_OP_LSB 1
`define SPW_CTRL_PTR_LSB 4
`define SPW_CTRL_ADDR 6
`define SPW_CTRL_LONG 7
`define SPW_PINS_PAUSE 0
`define SPW_PINS_PROTECT 1
`endif

// ### logic/spw_pkg.sv
// Types shared by both ends of the serial wiper control link.
package spw_pkg;
    typedef logic [9:0] spw_wiper_t;
    typedef enum logic [2:0]
    {
        SPW_HS_IDLE = 3'h0,
        SPW_HS_SETUP = 3'h1,
        SPW_HS_SHIFT = 3'h3,
        SPW_HS_END = 3'h2,
        SPW_HS_GAP = 3'h6
    } spw_host_state_e;
endpackage

// ### logic/spw_link_if.sv
// Serial link between the wiper device and its host controller.
`timescale 1ns/1ns
`default_nettype none
interface spw_link_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic hold_n;
    logic wp_n;
    logic miso;
    logic miso_oe_n;
    logic sio_line;
    // The shared output wire idles high through a pull-up when nobody drives it.
    assign sio_line = miso_oe_n ? 1'b1 : miso;
    modport dev (input cs_n, input sck, input mosi, input hold_n, input wp_n,
                 output miso, output miso_oe_n);
    modport host (output cs_n, output sck, output mosi, output hold_n, output wp_n,
                  input sio_line);
endinterface
`default_nettype wire

// ### logic/spw_tap_decode.sv
// One-hot decoder from wiper position to tap switch enables.
`timescale 1ns/1ns
`default_nettype none
module spw_tap_decode
    import spw_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire spw_pkg::spw_wiper_t i_wiper,
    output logic [1023:0] o_tap_enable
);
    // Registered so that exactly one switch is on, with no decode glitches.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
            o_tap_enable <= 1024'h1;
        else if (i_ce)
            o_tap_enable <= 1024'h1 << i_wiper;
    end
endmodule // spw_tap_decode
`default_nettype wire

// ### logic/spw_device.sv
// Serial slave and wiper position logic of the digital potentiometer.
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`include "spw_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module spw_device
    import spw_pkg::*;
#(
    parameter logic [3:0] P_TYPE_ID = 4'ha, // Arbitrary value.
    parameter int unsigned P_NV_WRITE_CYCLES = `SPW_T_NV_WRITE_US * `SPW_CLK_MHZ
)
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ce,
    spw_link_if.dev link,
    input wire logic i_address_strap_pin,
    output logic [1023:0] o_tap_enable,
    output spw_pkg::spw_wiper_t o_wiper_position_reg,
    output logic o_nv_write_busy_flag,
    output logic o_standby
);
    import spw_pkg::*;

    logic [5:0] meta_q;
    logic [5:0] sync_q;
    logic [1:0] prev_q;
    logic cs_n_s, sck_s, si_s, hold_n_s, wp_n_s, strap_s;
    logic sck_rise, sck_fall, cs_fall, cs_rise, active, byte_done;
    logic seen_high_q, framing_q, paused_q, ignore_q, rd_q, recall_q;
    logic [4:0] bit_cnt_q;
    logic [6:0] sh_q;
    logic [7:0] rx_byte;
    logic [3:0] cmd_q;
    logic [3:0] cmd_now;
    logic [1:0] ptr_q;
    logic [1:0] hi_q;
    logic pend_q;
    logic [1:0] pend_slot_q;
    spw_wiper_t pend_data_q;
    spw_wiper_t wiper_q;
    spw_wiper_t store_q [4];
    logic [15:0] out_q;
    logic so_q;
    logic [21:0] busy_cnt_q;
    logic commit;
    logic ld_direct, ld_xfer;

    // Two flip-flops on every pin; only the second stage is read below.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            meta_q <= `SPW_SYNC_RST;
            sync_q <= `SPW_SYNC_RST;
            prev_q <= 2'h1;
        end
        else if (i_ce)
        begin
            meta_q <= {i_address_strap_pin, link.wp_n, link.hold_n, link.mosi, link.sck,
                       link.cs_n};
            sync_q <= meta_q;
            prev_q <= {sync_q[1], sync_q[0]};
        end
    end

    assign cs_n_s = sync_q[0];
    assign sck_s = sync_q[1];
    assign si_s = sync_q[2];
    assign hold_n_s = sync_q[3];
    assign wp_n_s = sync_q[4];
    assign strap_s = sync_q[5];
    assign sck_rise = sck_s & ~prev_q[1];
    assign sck_fall = ~sck_s & prev_q[1];
    assign cs_fall = ~cs_n_s & prev_q[0] & seen_high_q;
    assign cs_rise = cs_n_s & ~prev_q[0];
    // A frame is live only while selected, not paused and not dropped.
    assign active = framing_q & ~cs_n_s & ~paused_q & ~ignore_q;
    assign byte_done = sck_rise & active & (bit_cnt_q[2:0] == 3'h7);
    assign rx_byte = {sh_q, si_s};
    assign cmd_now = {rx_byte[`SPW_ID_RW_BIT], rx_byte[`SPW_IN_OP_MSB:`SPW_IN_OP_LSB]};

    // Select tracking; serial activity after reset waits for a fresh select fall.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            seen_high_q <= 1'b0;
            framing_q <= 1'b0;
        end
        else if (i_ce)
        begin
            if (cs_n_s)
                seen_high_q <= 1'b1;
            if (cs_fall)
                framing_q <= 1'b1;
            else if (cs_n_s)
                framing_q <= 1'b0;
        end
    end

    // Hold only acts while the serial clock is low, so no partial edge is lost.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
            paused_q <= 1'b0;
        else if (i_ce)
        begin
            if (cs_n_s)
                paused_q <= 1'b0;
            else if (framing_q && !sck_s)
                paused_q <= ~hold_n_s;
        end
    end

    // Input shifter; the bit count survives a pause untouched.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            bit_cnt_q <= 5'h0;
            sh_q <= 7'h0;
        end
        else if (i_ce)
        begin
            if (cs_fall)
                bit_cnt_q <= 5'h0;
            else if (sck_rise && active)
            begin
                bit_cnt_q <= bit_cnt_q + 5'h1;
                sh_q <= rx_byte[6:0];
            end
        end
    end

    // Byte decode: identification, instruction, then two data bytes.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            ignore_q <= 1'b0;
            rd_q <= 1'b0;
            cmd_q <= 4'h0;
            ptr_q <= 2'h0;
            hi_q <= 2'h0;
        end
        else if (i_ce)
        begin
            if (cs_fall)
            begin
                ignore_q <= 1'b0;
                rd_q <= 1'b0;
            end
            else if (byte_done)
            begin
                case (bit_cnt_q[4:3])
                    2'h0:
                    begin
                        cmd_q[3] <= rx_byte[`SPW_ID_RW_BIT];
                        if (rx_byte[`SPW_ID_TYPE_MSB:`SPW_ID_TYPE_LSB] != P_TYPE_ID ||
                            rx_byte[`SPW_ID_ADDR_BIT] != strap_s)
                            ignore_q <= 1'b1;
                    end
                    2'h1:
                    begin
                        cmd_q[2:0] <= rx_byte[`SPW_IN_OP_MSB:`SPW_IN_OP_LSB];
                        ptr_q <= rx_byte[`SPW_IN_PTR_MSB:`SPW_IN_PTR_LSB];
                        case ({cmd_q[3], cmd_now[2:0]})
                            `SPW_CMD_RD_WIPER, `SPW_CMD_RD_STORE, `SPW_CMD_RD_STATUS:
                                rd_q <= 1'b1;
                            `SPW_CMD_WR_WIPER, `SPW_CMD_WR_STORE:
                                rd_q <= 1'b0;
                            default:
                                ignore_q <= 1'b1; // Transfers end here; unknown drops.
                        endcase
                    end
                    2'h2:
                        hi_q <= rx_byte[1:0];
                    default:
                        ignore_q <= 1'b1; // Extra clocks after the last byte are dropped.
                endcase
            end
        end
    end

    assign ld_direct = byte_done && bit_cnt_q[4:3] == 2'h3 && cmd_q == `SPW_CMD_WR_WIPER;
    assign ld_xfer = byte_done && bit_cnt_q[4:3] == 2'h1 &&
                     {cmd_q[3], cmd_now[2:0]} == `SPW_CMD_XFR_TO_WIPER;

    // Wiper: recall after power-up, direct load, or copy from a stored slot.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            wiper_q <= `SPW_WIPER_RST;
            recall_q <= 1'b1;
        end
        else if (i_ce)
        begin
            recall_q <= 1'b0;
            if (recall_q)
                wiper_q <= store_q[0];
            else if (ld_direct)
                wiper_q <= {hi_q, rx_byte};
            else if (ld_xfer)
                wiper_q <= store_q[rx_byte[`SPW_IN_PTR_MSB:`SPW_IN_PTR_LSB]];
        end
    end

    // A store write is armed by a complete sequence and fired by select rising.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            pend_q <= 1'b0;
            pend_slot_q <= 2'h0;
            pend_data_q <= `SPW_WIPER_RST;
        end
        else if (i_ce)
        begin
            if (cs_fall || cs_rise)
                pend_q <= 1'b0;
            else if (byte_done && bit_cnt_q[4:3] == 2'h3 && cmd_q == `SPW_CMD_WR_STORE)
            begin
                pend_q <= 1'b1;
                pend_slot_q <= ptr_q;
                pend_data_q <= {hi_q, rx_byte};
            end
            else if (byte_done && bit_cnt_q[4:3] == 2'h1 &&
                     {cmd_q[3], cmd_now[2:0]} == `SPW_CMD_XFR_TO_STORE)
            begin
                pend_q <= 1'b1;
                pend_slot_q <= rx_byte[`SPW_IN_PTR_MSB:`SPW_IN_PTR_LSB];
                pend_data_q <= wiper_q;
            end
        end
    end

    // Protect low, or a write still running, drops the armed write.
    assign commit = cs_rise & pend_q & wp_n_s & ~o_nv_write_busy_flag;

    // Stored slots; the reset stands in for factory-fresh contents.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            for (int i = 0; i < 4; i++)
                store_q[i] <= `SPW_STORE_RST;
        end
        else if (i_ce && commit)
            store_q[pend_slot_q] <= pend_data_q;
    end

    // Busy timer models the high-voltage write time.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
            busy_cnt_q <= 22'h0;
        else if (i_ce)
        begin
            if (commit)
                busy_cnt_q <= 22'(P_NV_WRITE_CYCLES);
            else if (busy_cnt_q != 22'h0)
                busy_cnt_q <= busy_cnt_q - 22'h1;
        end
    end

    // Read shifter: loaded after the instruction byte, moved on falling clock.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            out_q <= 16'h0;
            so_q <= 1'b0;
        end
        else if (i_ce)
        begin
            if (byte_done && bit_cnt_q[4:3] == 2'h1)
            begin
                case ({cmd_q[3], cmd_now[2:0]})
                    `SPW_CMD_RD_WIPER:
                        out_q <= {6'h0, wiper_q};
                    `SPW_CMD_RD_STORE:
                        out_q <= {6'h0, store_q[rx_byte[`SPW_IN_PTR_MSB:`SPW_IN_PTR_LSB]]};
                    `SPW_CMD_RD_STATUS:
                        out_q <= {15'h0, o_nv_write_busy_flag};
                    default:
                        out_q <= 16'h0;
                endcase
            end
            else if (sck_fall && active && rd_q)
            begin
                so_q <= out_q[15];
                out_q <= {out_q[14:0], 1'b0};
            end
        end
    end

    assign link.miso = so_q;
    assign link.miso_oe_n = ~(active & rd_q);
    assign o_wiper_position_reg = wiper_q;
    assign o_nv_write_busy_flag = busy_cnt_q != 22'h0;
    assign o_standby = cs_n_s & ~o_nv_write_busy_flag;

    spw_tap_decode u_decode
    (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_wiper(wiper_q),
        .o_tap_enable(o_tap_enable)
    );
endmodule // spw_device
`default_nettype wire

// ### logic/spw_host.sv
// Host controller: Wishbone registers in, serial frames to the wiper device out.
`include "spw_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module spw_host
    import spw_pkg::*;
#(
    parameter logic [3:0] P_TYPE_ID = 4'ha // Arbitrary value.
)
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    spw_link_if.host link
);
    import spw_pkg::*;

    spw_host_state_e state_q;
    logic [1:0] miso_q;
    logic [31:0] tx_q;
    logic [15:0] rx_q;
    logic [9:0] txd_q;
    logic [1:0] pins_q;
    logic [5:0] bits_q;
    logic [5:0] nbits_q;
    logic [3:0] div_q;
    logic sck_q, cs_n_q, hold_n_q, wp_n_q;
    logic wr, go, tick;

    assign wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack & i_wb_sel[0];
    assign go = wr && i_wb_adr == `SPW_REG_CTRL && state_q == SPW_HS_IDLE;
    assign tick = div_q == 4'(`SPW_SCK_HALF - 1);

    // Single-cycle ack; writes land on the edge at which the master sees the ack.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
            txd_q <= 10'h0;
            pins_q <= 2'h0;
        end
        else if (i_ce)
        begin
            o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
            if (wr && i_wb_adr == `SPW_REG_TXDATA)
                txd_q <= i_wb_dat[9:0];
            if (wr && i_wb_adr == `SPW_REG_PINS)
                pins_q <= i_wb_dat[1:0];
            case (i_wb_adr)
                `SPW_REG_TXDATA: o_wb_dat <= {22'h0, txd_q};
                `SPW_REG_RXDATA: o_wb_dat <= {16'h0, rx_q};
                `SPW_REG_STATUS: o_wb_dat <= {30'h0, ~hold_n_q, state_q != SPW_HS_IDLE};
                `SPW_REG_PINS: o_wb_dat <= {30'h0, pins_q};
                default: o_wb_dat <= 32'h0;
            endcase
        end
    end

    // Device output is foreign to this clock: two flip-flops first.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
            miso_q <= 2'h3;
        else if (i_ce)
            miso_q <= {miso_q[0], link.sio_line};
    end

    // Pause only while the clock is low, so the device never sees half an edge.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
            hold_n_q <= 1'b1;
        else if (i_ce)
        begin
            if (state_q == SPW_HS_SHIFT && !sck_q)
                hold_n_q <= ~pins_q[`SPW_PINS_PAUSE];
            else if (state_q == SPW_HS_IDLE)
                hold_n_q <= 1'b1;
        end
    end

    // Frame sequencer with clock divider.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_q <= SPW_HS_IDLE;
            cs_n_q <= 1'b1;
            sck_q <= 1'b0;
            wp_n_q <= 1'b1;
            div_q <= 4'h0;
            bits_q <= 6'h0;
            nbits_q <= 6'h0;
            tx_q <= 32'h0;
            rx_q <= 16'h0;
        end
        else if (i_ce)
        begin
            div_q <= (tick || state_q == SPW_HS_IDLE || !hold_n_q) ? 4'h0 : div_q + 4'h1;
            case (state_q)
                SPW_HS_IDLE:
                    if (go)
                    begin
                        tx_q <= {P_TYPE_ID, 2'h0, i_wb_dat[`SPW_CTRL_ADDR],
                                 i_wb_dat[`SPW_CTRL_RW], i_wb_dat[`SPW_CTRL_OP_LSB +: 3],
                                 1'b0, i_wb_dat[`SPW_CTRL_PTR_LSB +: 2], 2'h0,
                                 6'h0, txd_q};
                        nbits_q <= i_wb_dat[`SPW_CTRL_LONG] ? `SPW_BITS_LONG
                                                            : `SPW_BITS_SHORT;
                        bits_q <= 6'h0;
                        wp_n_q <= ~pins_q[`SPW_PINS_PROTECT];
                        cs_n_q <= 1'b0;
                        state_q <= SPW_HS_SETUP;
                    end
                SPW_HS_SETUP:
                    if (tick)
                        state_q <= SPW_HS_SHIFT;
                SPW_HS_SHIFT:
                    if (tick && hold_n_q)
                    begin
                        if (!sck_q)
                        begin
                            sck_q <= 1'b1;
                            rx_q <= {rx_q[14:0], miso_q[1]};
                            bits_q <= bits_q + 6'h1;
                        end
                        else
                        begin
                            sck_q <= 1'b0;
                            tx_q <= {tx_q[30:0], 1'b0};
                            if (bits_q == nbits_q)
                                state_q <= SPW_HS_END;
                        end
                    end
                SPW_HS_END:
                    if (tick)
                    begin
                        cs_n_q <= 1'b1;
                        state_q <= SPW_HS_GAP;
                    end
                SPW_HS_GAP:
                    if (tick)
                    begin
                        wp_n_q <= 1'b1;
                        state_q <= SPW_HS_IDLE;
                    end
                default:
                    state_q <= SPW_HS_IDLE;
            endcase
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.sck = sck_q;
    assign link.mosi = tx_q[31];
    assign link.hold_n = hold_n_q;
    assign link.wp_n = wp_n_q;
endmodule // spw_host
`default_nettype wire

// ### verification/spw_link_chk.sv
// Concurrent checks on the serial link between the host and the wiper device.
`timescale 1ns/1ns
`default_nettype none
module spw_link_chk
    import spw_pkg::*;
#(
    parameter int unsigned P_NV_WRITE_CYCLES = 20
)
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_hold_n,
    input wire logic i_miso,
    input wire logic i_miso_oe_n,
    input wire logic [1023:0] i_tap_enable,
    input wire spw_pkg::spw_wiper_t i_wiper_position_reg,
    input wire logic i_nv_write_busy_flag
);
    import spw_pkg::*;
    logic [31:0] busy_cnt_q;

    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);

    // Length of the current stored write, so its duration can be checked exactly.
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
            busy_cnt_q <= 32'h0;
        else if (!i_nv_write_busy_flag)
            busy_cnt_q <= 32'h0;
        else
            busy_cnt_q <= busy_cnt_q + 32'h1;
    end

    // The synchroniser lets the output linger a few cycles after select rises.
    sequence desel_s;
        i_cs_n [*5];
    endsequence
    sequence paused_s;
        !i_hold_n [*5];
    endsequence

    // Output enable and data timing on the shared wire.
    desel_off_a: assert property (desel_s |-> i_miso_oe_n)
        else $error("serial output driven while deselected");
    pause_off_a: assert property (paused_s |-> i_miso_oe_n)
        else $error("serial output driven while paused");
    miso_fall_a: assert property (($changed(i_miso) && !i_miso_oe_n) |-> !i_sck)
        else $error("serial output changed while clock high");
    // Tap selection follows the wiper by one cycle and stays one-hot.
    tap_onehot_a: assert property ($onehot(i_tap_enable))
        else $error("tap enables not one-hot");
    tap_follows_a: assert property (i_tap_enable ==
        (1024'h1 << $past(i_wiper_position_reg)))
        else $error("tap enable does not match wiper");
    wiper_in_frame_a: assert property ($changed(i_wiper_position_reg) |-> !i_cs_n)
        else $error("wiper changed outside a frame");
    // Stored writes start only at deselect and last the programmed time.
    busy_start_a: assert property ($rose(i_nv_write_busy_flag) |-> i_cs_n)
        else $error("stored write began while selected");
    busy_len_a: assert property ($fell(i_nv_write_busy_flag) |->
        busy_cnt_q == P_NV_WRITE_CYCLES)
        else $error("stored write length wrong");
endmodule // spw_link_chk
`default_nettype wire

// ### verification/spi_pot_wiper_control_test.sv
// Self-checking bench: host and wiper device joined over the serial link.
`include "spw_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module spi_pot_wiper_control_test;
    import spw_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic strap = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] r;
    logic ack;
    logic busy;
    logic stby;
    logic [1023:0] tap;
    spw_wiper_t wiper;
    int n_mismatch = 0;
    int check_count = 0;
    spw_link_if link();

    // System clock, 4 ns period.
    always #2 clk = ~clk;

    spw_host spw_host_inst (.i_clk_sys(clk), .i_reset(rst), .i_ce(1'b1), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf),
        .o_wb_dat(rdat), .o_wb_ack(ack), .link(link));
    spw_device #(.P_NV_WRITE_CYCLES(20)) spw_device_inst (.i_clk_sys(clk), .i_reset(rst),
        .i_ce(1'b1), .link(link), .i_address_strap_pin(strap), .o_tap_enable(tap),
        .o_wiper_position_reg(wiper), .o_nv_write_busy_flag(busy), .o_standby(stby));
    spw_link_chk #(.P_NV_WRITE_CYCLES(20)) spw_link_chk_inst (.i_clk_sys(clk), .i_reset(rst),
        .i_cs_n(link.cs_n), .i_sck(link.sck), .i_hold_n(link.hold_n), .i_miso(link.miso),
        .i_miso_oe_n(link.miso_oe_n), .i_tap_enable(tap), .i_wiper_position_reg(wiper),
        .i_nv_write_busy_flag(busy));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic Wishbone cycle; waits for ack, which only the watchdog can cut short.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Runs one frame, polls until the host is idle, then fetches the received word.
    task automatic frame(input logic [3:0] key, input logic [1:0] ptr, input logic a,
        input logic lng, input logic [9:0] d);
        int i;
        wb(1'b1, `SPW_REG_TXDATA, {22'h0, d});
        wb(1'b1, `SPW_REG_CTRL, {24'h0, lng, a, ptr, key[2:0], key[3]});
        for (i = 0; i < 2000; i++)
        begin
            wb(1'b0, `SPW_REG_STATUS, 32'h0);
            if (r[0] === 1'b0)
                break;
        end
        wb(1'b0, `SPW_REG_RXDATA, 32'h0);
    endtask

    task automatic t_recall();
        chk(wiper, 32'h0);
        chk(tap[0], 32'h1);
        chk(link.miso_oe_n, 32'h1);
        chk(stby, 32'h1);
    endtask

    // Extreme and mixed wiper values, each written then read back.
    task automatic t_wiper();
        spw_wiper_t v[2] = '{10'h3ff, 10'h2a5};
        foreach (v[k])
        begin
            frame(`SPW_CMD_WR_WIPER, 2'h0, 1'b1, 1'b1, v[k]);
            chk(wiper, v[k]);
            chk(tap[v[k]], 32'h1);
            frame(`SPW_CMD_RD_WIPER, 2'h0, 1'b1, 1'b1, 10'h0);
            chk(r[15:0], {6'h0, v[k]});
        end
    endtask

    // Wrong address bit: nothing changes and the pulled-up wire reads all ones.
    task automatic t_addr();
        frame(`SPW_CMD_WR_WIPER, 2'h0, 1'b0, 1'b1, 10'h123);
        chk(wiper, 32'h2a5);
        frame(`SPW_CMD_RD_WIPER, 2'h0, 1'b0, 1'b1, 10'h0);
        chk(r[15:0], 32'hffff);
    endtask

    task automatic t_store();
        frame(`SPW_CMD_WR_STORE, 2'h2, 1'b1, 1'b1, 10'h155);
        chk(busy, 32'h1);
        chk(stby, 32'h0);
        repeat (40) @(posedge clk);
        chk(busy, 32'h0);
        frame(`SPW_CMD_RD_STATUS, 2'h0, 1'b1, 1'b1, 10'h0);
        chk(r[15:0], 32'h0);
        frame(`SPW_CMD_XFR_TO_WIPER, 2'h2, 1'b1, 1'b0, 10'h0);
        chk(wiper, 32'h155);
        frame(`SPW_CMD_XFR_TO_STORE, 2'h1, 1'b1, 1'b0, 10'h0);
        frame(`SPW_CMD_RD_STORE, 2'h1, 1'b1, 1'b1, 10'h0);
        chk(r[15:0], 32'h155);
        frame(`SPW_CMD_RD_STORE, 2'h2, 1'b1, 1'b1, 10'h0);
        chk(r[15:0], 32'h155);
    endtask

    task automatic t_protect();
        wb(1'b1, `SPW_REG_PINS, 32'h2);
        frame(`SPW_CMD_WR_STORE, 2'h3, 1'b1, 1'b1, 10'h0ff);
        chk(busy, 32'h0);
        wb(1'b1, `SPW_REG_PINS, 32'h0);
        frame(`SPW_CMD_RD_STORE, 2'h3, 1'b1, 1'b1, 10'h0);
        chk(r[15:0], 32'h0);
    endtask

    // Pause in mid-frame: the device keeps its place and ends the frame after the resume.
    task automatic t_pause();
        int i;
        wb(1'b1, `SPW_REG_TXDATA, 32'h0c3);
        wb(1'b1, `SPW_REG_CTRL, 32'hca);
        repeat (200) @(posedge clk);
        wb(1'b1, `SPW_REG_PINS, 32'h1);
        repeat (100) @(posedge clk);
        wb(1'b0, `SPW_REG_STATUS, 32'h0);
        chk(r[1:0], 32'h3);
        chk(wiper, 32'h155);
        wb(1'b1, `SPW_REG_PINS, 32'h0);
        for (i = 0; i < 2000; i++)
        begin
            wb(1'b0, `SPW_REG_STATUS, 32'h0);
            if (r[0] === 1'b0)
                break;
        end
        chk(wiper, 32'h0c3);
    endtask

    // A reset in mid-run drops the volatile wiper back to the recalled slot zero.
    task automatic t_reset();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(wiper, 32'h0);
        chk(busy, 32'h0);
        frame(`SPW_CMD_RD_WIPER, 2'h0, 1'b1, 1'b1, 10'h0);
        chk(r[15:0], 32'h0);
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence: reset for 16 cycles, then each scenario in turn.
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_recall();
        t_wiper();
        t_addr();
        t_store();
        t_protect();
        t_pause();
        t_reset();
        end_of_test();
    end

    // Watchdog: the scenarios need a little under a tenth of this span.
    initial
    begin
        #400000;
        n_mismatch++;
        end_of_test();
    end
endmodule // spi_pot_wiper_control_test
`default_nettype wire
